// ===== hw/odf_filter_chan.sv
// Purpose: one glitch filter channel
// Assumes: tick from shared divider, input already synchronised
// Notes:   first tick of a change may be partial, so four ticks are needed
`timescale 1ns/1ps
`default_nettype none
`include "odf_defines.svh"
module odf_filter_chan (
  input  wire logic i_clock,
  input  wire logic i_rst_n,
  input  wire logic i_clk_en,
  input  wire logic i_tick,
  input  wire logic i_bypass,
  input  wire logic i_in,
  output var  logic o_out
);
  logic       out_ff;
  logic [1:0] cnt_ff;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      out_ff <= 1'b0;
      cnt_ff <= 2'h0;
    end else if (i_clk_en) begin
      if (i_bypass) begin
        out_ff <= i_in;
        cnt_ff <= 2'h0;
      end else if (i_in == out_ff) begin
        cnt_ff <= 2'h0;
      end else if (i_tick) begin
        if (cnt_ff == `ODF_STABLE_TICKS) begin
          out_ff <= i_in;
          cnt_ff <= 2'h0;
        end else begin
          cnt_ff <= cnt_ff + 2'h1;
        end
      end
    end
  end

  assign o_out = out_ff;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  sequence s_full_wait;
    i_tick && i_clk_en && !i_bypass && (cnt_ff == 2'h3) && (i_in != out_ff);
  endsequence

  a_bypass_pass: assert property ((i_bypass && i_clk_en) |=> (out_ff == $past(i_in)))
    else $error("bypass did not pass input through");
  a_accept_late: assert property (s_full_wait |=> (out_ff == $past(i_in)))
    else $error("stable change not accepted");
  a_reject_early: assert property (($changed(out_ff) && !$past(i_bypass)) |-> ($past(cnt_ff) == 2'h3))
    else $error("change accepted before stable window");
  a_glitch_clear: assert property (((i_in == out_ff) && i_clk_en) |=> (cnt_ff == 2'h0))
    else $error("stability counter not cleared");
endmodule : odf_filter_chan
`default_nettype wire

// ===== hw/odf_top.sv
// Purpose: octal input debounce with supply and temperature alarms
// Assumes: comparator decisions and monitor levels arrive asynchronously
// Notes:   registers over Avalon-MM, one wait state per access
//
// Added by the designer: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "odf_defines.svh"
module odf_top #(
  parameter int         N_CH         = 8,
  parameter int         CNT_W        = 15,
  parameter logic [14:0] P_TICK_750US = 15'(`ODF_TICKS(`ODF_DB_750US_NS)),
  parameter logic [14:0] P_TICK_3MS   = 15'(`ODF_TICKS(`ODF_DB_3MS_NS))
) (
  input  wire logic              I_CLOCK,
  input  wire logic              I_RST_N,
  input  wire logic              I_CLK_EN,
  input  wire logic [N_CH-1:0]   I_FIELD_INPUTS,
  input  wire logic              I_DEBOUNCE_SEL_LO,
  input  wire logic              I_DEBOUNCE_SEL_HI,
  input  wire logic              I_THRESHOLD_MODE_SEL,
  input  wire logic              I_OVERTEMP_LIMIT,
  input  wire logic              I_SUPPLY_OFF_THRESHOLD,
  input  wire logic              I_SUPPLY_ON_THRESHOLD,
  input  wire logic              I_REGULATOR_OUT_PIN,
  input  wire logic [3:0]        I_AVS_ADDRESS,
  input  wire logic              I_AVS_READ,
  input  wire logic              I_AVS_WRITE,
  input  wire logic [31:0]       I_AVS_WRITEDATA,
  input  wire logic [3:0]        I_AVS_BYTEENABLE,
  output var  logic [31:0]       O_AVS_READDATA,
  output var  logic              O_AVS_WAITREQUEST,
  output var  logic [N_CH-1:0]   O_LOGIC_OUTPUTS,
  output var  logic              O_SUPPLY_LOW_ALARM_N,
  output var  logic              O_FAULT_ALARM_N,
  output var  logic              O_IRQ
);
  localparam int        SYNC_W  = N_CH + 7;
  localparam logic [14:0] TICK_25US = 15'(`ODF_TICKS(`ODF_DB_25US_NS));

  // two-stage synchroniser; only sync_ff is read
  logic [SYNC_W-1:0] meta_ff;
  logic [SYNC_W-1:0] sync_ff;

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else if (I_CLK_EN) begin
      meta_ff <= {I_REGULATOR_OUT_PIN, I_SUPPLY_ON_THRESHOLD, I_SUPPLY_OFF_THRESHOLD,
                  I_OVERTEMP_LIMIT, I_THRESHOLD_MODE_SEL, I_DEBOUNCE_SEL_HI,
                  I_DEBOUNCE_SEL_LO, I_FIELD_INPUTS};
      sync_ff <= meta_ff;
    end
  end

  logic [N_CH-1:0]         field_s;
  odf_pkg::odf_dbsel_t     sel_s;
  logic                    tsel_s;
  logic                    ot_s;
  logic                    below_off_s;
  logic                    above_on_s;
  logic                    reg_s;

  // decision polarity kept: 1 is sensor on
  assign field_s     = sync_ff[N_CH-1:0];
  assign sel_s       = odf_pkg::odf_dbsel_t'(sync_ff[N_CH+1:N_CH]);
  assign tsel_s      = sync_ff[N_CH+2];
  assign ot_s        = sync_ff[N_CH+3];
  assign below_off_s = sync_ff[N_CH+4];
  assign above_on_s  = sync_ff[N_CH+5];
  assign reg_s       = sync_ff[N_CH+6];

  // shared filter clock divider
  logic [CNT_W-1:0] tick_lim;
  logic [CNT_W-1:0] tick_cnt_ff;
  logic             bypass;
  logic             tick;

  always_comb begin
    case (sel_s)
      odf_pkg::ODF_SEL_NONE:  tick_lim = '0;
      odf_pkg::ODF_SEL_25US:  tick_lim = CNT_W'(TICK_25US - 15'h1);
      odf_pkg::ODF_SEL_750US: tick_lim = CNT_W'(P_TICK_750US - 15'h1);
      odf_pkg::ODF_SEL_3MS:   tick_lim = CNT_W'(P_TICK_3MS - 15'h1);
      default:                tick_lim = '0;
    endcase
  end

  assign bypass = (sel_s == odf_pkg::ODF_SEL_NONE);
  // >= so a shorter setting takes effect at once
  assign tick   = !bypass && (tick_cnt_ff >= tick_lim);

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      tick_cnt_ff <= '0;
    end else if (I_CLK_EN) begin
      if (bypass || tick) begin
        tick_cnt_ff <= '0;
      end else begin
        tick_cnt_ff <= tick_cnt_ff + CNT_W'(1);
      end
    end
  end

  logic [N_CH-1:0] filt_out;

  genvar gi;
  generate
    for (gi = 0; gi < N_CH; gi++) begin : g_chan
      odf_filter_chan u_chan (
        .i_clock  (I_CLOCK),
        .i_rst_n  (I_RST_N),
        .i_clk_en (I_CLK_EN),
        .i_tick   (tick),
        .i_bypass (bypass),
        .i_in     (field_s[gi]),
        .o_out    (filt_out[gi])
      );
    end
  endgenerate

  assign O_LOGIC_OUTPUTS = filt_out;

  // alarms; reset shows them asserted until the monitors are seen
  logic uv_ff;
  logic nxt_uv;
  logic alarm_uv_ff;
  logic alarm_fault_ff;
  logic ot_ff;
  logic nxt_alarm_uv;
  logic nxt_alarm_fault;

  always_comb begin
    nxt_uv = uv_ff;
    if (below_off_s) begin
      nxt_uv = 1'b1;
    end else if (above_on_s) begin
      nxt_uv = 1'b0;
    end
  end

  // regulator powering forces the supply-low alarm and through it the combined alarm; uv_ff and ot_ff still follow the monitors
  assign nxt_alarm_uv    = nxt_uv || reg_s;
  assign nxt_alarm_fault = nxt_alarm_uv || ot_s;

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      uv_ff          <= 1'b1;
      alarm_uv_ff    <= 1'b1;
      alarm_fault_ff <= 1'b1;
      ot_ff          <= 1'b0;
    end else if (I_CLK_EN) begin
      uv_ff          <= nxt_uv;
      alarm_uv_ff    <= nxt_alarm_uv;
      alarm_fault_ff <= nxt_alarm_fault;
      ot_ff          <= ot_s;
    end
  end

  assign O_SUPPLY_LOW_ALARM_N = !alarm_uv_ff;
  assign O_FAULT_ALARM_N      = !alarm_fault_ff;

  // interrupt events
  logic [N_CH-1:0]        out_prev_ff;
  logic [`ODF_IRQ_W-1:0]  ev_set;
  logic [`ODF_IRQ_W-1:0]  irq_stat_ff;
  logic [`ODF_IRQ_W-1:0]  irq_mask_ff;
  logic [`ODF_IRQ_W-1:0]  irq_clr;
  logic                   irq_ff;

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      out_prev_ff <= '0;
    end else if (I_CLK_EN) begin
      out_prev_ff <= filt_out;
    end
  end

  always_comb begin
    ev_set                  = '0;
    ev_set[N_CH-1:0]        = filt_out ^ out_prev_ff;
    ev_set[`ODF_IRQ_OT]     = ot_s && !ot_ff;
    ev_set[`ODF_IRQ_UV]     = nxt_alarm_uv && !alarm_uv_ff;
  end

  // avalon slave, one wait state
  logic        ack_ff;
  logic        req;
  logic        wr_done;
  logic [31:0] rdata_ff;

  function automatic logic hit(input logic [3:0] addr, input logic [3:0] offs);
    hit = (addr[3:2] == offs[3:2]);
  endfunction : hit

  assign req               = I_AVS_READ || I_AVS_WRITE;
  assign O_AVS_WAITREQUEST = req && !(ack_ff && I_CLK_EN);
  assign wr_done           = I_AVS_WRITE && ack_ff && I_CLK_EN;

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ack_ff <= 1'b0;
    end else if (I_CLK_EN) begin
      ack_ff <= req && !ack_ff;
    end
  end

  always_comb begin
    irq_clr = '0;
    if (wr_done && hit(I_AVS_ADDRESS, `ODF_REG_IRQ_STAT)) begin
      if (I_AVS_BYTEENABLE[0]) begin
        irq_clr[7:0] = I_AVS_WRITEDATA[7:0];
      end
      if (I_AVS_BYTEENABLE[1]) begin
        irq_clr[`ODF_IRQ_W-1:8] = I_AVS_WRITEDATA[`ODF_IRQ_W-1:8];
      end
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      irq_stat_ff <= '0;
    end else if (I_CLK_EN) begin
      // set wins over a simultaneous clear
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | ev_set;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      irq_mask_ff <= `ODF_IRQ_MASK_RST;
    end else if (wr_done && hit(I_AVS_ADDRESS, `ODF_REG_IRQ_MASK)) begin
      if (I_AVS_BYTEENABLE[0]) begin
        irq_mask_ff[7:0] <= I_AVS_WRITEDATA[7:0];
      end
      if (I_AVS_BYTEENABLE[1]) begin
        irq_mask_ff[`ODF_IRQ_W-1:8] <= I_AVS_WRITEDATA[`ODF_IRQ_W-1:8];
      end
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      irq_ff <= 1'b0;
    end else if (I_CLK_EN) begin
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  assign O_IRQ = irq_ff;

  logic [31:0] nxt_rdata;

  always_comb begin
    nxt_rdata = 32'h00000000;
    if (hit(I_AVS_ADDRESS, `ODF_REG_INPUTS)) begin
      nxt_rdata[N_CH-1:0] = filt_out;
    end else if (hit(I_AVS_ADDRESS, `ODF_REG_ALARMS)) begin
      nxt_rdata[`ODF_ALM_OT]       = ot_ff;
      nxt_rdata[`ODF_ALM_UV]       = alarm_uv_ff;
      nxt_rdata[`ODF_ALM_REGMODE]  = reg_s;
      nxt_rdata[`ODF_ALM_TSEL]     = tsel_s;
      nxt_rdata[`ODF_ALM_DBSEL_LO] = sel_s[0];
      nxt_rdata[`ODF_ALM_DBSEL_HI] = sel_s[1];
    end else if (hit(I_AVS_ADDRESS, `ODF_REG_IRQ_STAT)) begin
      nxt_rdata[`ODF_IRQ_W-1:0] = irq_stat_ff;
    end else if (hit(I_AVS_ADDRESS, `ODF_REG_IRQ_MASK)) begin
      nxt_rdata[`ODF_IRQ_W-1:0] = irq_mask_ff;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rdata_ff <= 32'h00000000;
    end else if (I_CLK_EN && I_AVS_READ && !ack_ff) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign O_AVS_READDATA = rdata_ff;

  // checks; helper counts cycles between filter ticks
  logic [CNT_W-1:0]    gap_ff;
  logic                sel_chg_ff;
  odf_pkg::odf_dbsel_t sel_prev_ff;
  logic                sel_moved;

  // select change seen after the second stage only, never on the first
  assign sel_moved = (sel_s != sel_prev_ff);

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      gap_ff      <= '0;
      sel_chg_ff  <= 1'b0;
      sel_prev_ff <= odf_pkg::ODF_SEL_NONE;
    end else if (I_CLK_EN) begin
      gap_ff      <= tick ? '0 : gap_ff + CNT_W'(1);
      sel_chg_ff  <= tick ? 1'b0 : (sel_chg_ff || sel_moved);
      sel_prev_ff <= sel_s;
    end
  end

  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);

  sequence s_supply_drop;
    below_off_s && I_CLK_EN;
  endsequence

  sequence s_alarms_low;
    !O_SUPPLY_LOW_ALARM_N && !O_FAULT_ALARM_N;
  endsequence

  sequence s_bus_req;
    (I_AVS_READ || I_AVS_WRITE) && !ack_ff && I_CLK_EN;
  endsequence

  a_tick_period: assert property ((tick && I_CLK_EN && !sel_chg_ff && !sel_moved)
      |-> (gap_ff == tick_lim))
    else $error("filter tick period wrong");
  a_sel_3ms: assert property ((tick && I_CLK_EN && !sel_chg_ff && !sel_moved
      && (sel_s == odf_pkg::ODF_SEL_3MS)) |-> (gap_ff == CNT_W'(P_TICK_3MS - 15'h1)))
    else $error("3 ms setting divider wrong");
  a_uv_assert: assert property (s_supply_drop |=> s_alarms_low)
    else $error("supply drop not flagged");
  a_uv_hyst: assert property ((uv_ff && !above_on_s && I_CLK_EN) |=> uv_ff)
    else $error("supply alarm released without on threshold");
  a_regmode_hold: assert property ((reg_s && I_CLK_EN) |=> s_alarms_low)
    else $error("regulator mode alarms not forced");
  a_overtemp: assert property ((ot_s && I_CLK_EN) |=> !O_FAULT_ALARM_N)
    else $error("overtemp not flagged");
  a_fault_or: assert property (O_FAULT_ALARM_N == (O_SUPPLY_LOW_ALARM_N && !ot_ff))
    else $error("combined alarm not or of sources");
  a_outputs_par: assert property ((bypass && I_CLK_EN) ##1 (bypass && I_CLK_EN) |=> (O_LOGIC_OUTPUTS == $past(field_s)))
    else $error("parallel outputs do not follow inputs");
  a_set_wins: assert property ((I_CLK_EN && (ev_set & irq_clr) != '0) |=> ((irq_stat_ff & $past(ev_set)) == $past(ev_set)))
    else $error("event lost under clear");
  a_ot_release: assert property ((!ot_s && !nxt_alarm_uv && I_CLK_EN) |=> O_FAULT_ALARM_N)
    else $error("combined alarm held without a source");
  a_bus_answer: assert property (s_bus_req |-> (O_AVS_WAITREQUEST ##1 (!O_AVS_WAITREQUEST || !I_CLK_EN)))
    else $error("bus answer not after one wait state");
  a_rdata_hold: assert property ((!(I_AVS_READ && !ack_ff && I_CLK_EN)) |=> $stable(O_AVS_READDATA))
    else $error("read data moved without a new read");
  a_irq_level: assert property (I_CLK_EN |=> (O_IRQ == |($past(irq_stat_ff) & $past(irq_mask_ff))))
    else $error("interrupt level not status and mask");
  // enable low freezes everything, bus acknowledge included
  a_freeze: assert property ((!I_CLK_EN) |=> ($stable(O_LOGIC_OUTPUTS) && $stable(O_FAULT_ALARM_N)
      && $stable(O_IRQ)))
    else $error("state moved while clock enable low");
endmodule : odf_top
`default_nettype wire

// ===== pkg/odf_defines.svh
// Purpose: constants for the octal input debounce and fault block
// Assumes: 20 MHz system clock
// Notes:   times in ns, tick counts derived from them
// How it works
// - eight debounced channel outputs are presented in parallel
// - four debounce settings: none, 25 us, 0.75 ms, 3 ms
// - select pair hi,lo: 00 none, 01 25 us, 10 0.75 ms, 11 3 ms
// - filter clock period is one third of the selected debounce time
// - a change passes only after three stable filter clocks, else dropped
// - zero setting passes each comparator decision straight through
// - comparator decision 1 means sensor on, 0 means off
// - combined alarm asserts while junction temperature exceeds its limit
// - supply below off threshold asserts supply-low and combined alarms
// - supply alarms release only above the separate on threshold
// - regulator-pin powering holds supply-low and combined alarms active
// - combined alarm is active low, or of overtemp and supply-low
`ifndef ODF_DEFINES_SVH
`define ODF_DEFINES_SVH
`define ODF_CLK_PERIOD_NS 50
`define ODF_DB_25US_NS    25000
`define ODF_DB_750US_NS   750000
`define ODF_DB_3MS_NS     3000000
`define ODF_FILT_DIV      3
`define ODF_TICKS(t) (((t) + `ODF_FILT_DIV * `ODF_CLK_PERIOD_NS - 1) / (`ODF_FILT_DIV * `ODF_CLK_PERIOD_NS))
`define ODF_STABLE_TICKS  2'h3
`define ODF_REG_INPUTS    4'h0
`define ODF_REG_ALARMS    4'h4
`define ODF_REG_IRQ_STAT  4'h8
`define ODF_REG_IRQ_MASK  4'hC
`define ODF_ALM_OT        0
`define ODF_ALM_UV        1
`define ODF_ALM_REGMODE   2
`define ODF_ALM_TSEL      3
`define ODF_ALM_DBSEL_LO  4
`define ODF_ALM_DBSEL_HI  5
`define ODF_IRQ_OT        8
`define ODF_IRQ_UV        9
`define ODF_IRQ_W         10
`define ODF_IRQ_MASK_RST  10'h000
`endif

// ===== pkg/odf_pkg.sv
// Purpose: shared types of the octal input debounce and fault block
// Assumes: nothing
// Notes:   debounce select encoding as seen on the pin pair
package odf_pkg;
  typedef enum logic [1:0] {
    ODF_SEL_NONE  = 2'b00,
    ODF_SEL_25US  = 2'b01,
    ODF_SEL_750US = 2'b10,
    ODF_SEL_3MS   = 2'b11
  } odf_dbsel_t;
endpackage : odf_pkg

// ===== verification/odf_field_model.sv
// Purpose: field-side model: sensors, field supply, die temperature
// Assumes: bench changes levels right after a rising clock edge
// Notes:   supply limits are plain defaults, not device figures
`timescale 1ns/1ps
`default_nettype none
module odf_field_model #(
  parameter int   OFF_V   = 9,
  parameter int   ON_V    = 11,
  parameter logic THR_IND = 1'b1
) (
  input  wire logic [7:0] i_sensor_on,
  input  wire logic [5:0] i_supply_v,
  input  wire logic       i_hot,
  input  wire logic       i_on_regulator,
  output var  logic [7:0] o_field_inputs,
  output var  logic       o_threshold_mode_sel,
  output var  logic       o_overtemp_limit,
  output var  logic       o_supply_off_threshold,
  output var  logic       o_supply_on_threshold,
  output var  logic       o_regulator_out_pin
);
  // decision 1 means the sensor is judged on
  assign o_field_inputs = i_sensor_on;
  assign o_threshold_mode_sel = THR_IND;
  assign o_overtemp_limit = i_hot;
  // field supply left open in regulator mode, so the monitor sees nothing
  assign o_supply_off_threshold = i_on_regulator || (int'(i_supply_v) < OFF_V);
  assign o_supply_on_threshold = !i_on_regulator && (int'(i_supply_v) > ON_V);
  assign o_regulator_out_pin = i_on_regulator;
endmodule : odf_field_model
`default_nettype wire

// ===== verification/odf_top_tb.sv
// Purpose: self-checking bench of the octal debounce and fault block
// Assumes: short tick parameters, clock enable high but for one freeze case
// Notes:   25 us setting keeps its full 167-cycle tick
`timescale 1ns/1ps
`default_nettype none
module odf_top_tb;
  localparam int N25 = 167;
  localparam int N750 = 20;
  localparam int N3 = 40;
  typedef struct {logic [1:0] sel; logic [7:0] pat; int len; logic [7:0] exp;} odf_row_t;
  logic        clk;
  logic        rst_n;
  logic        clk_en;
  logic [7:0]  sensor_on;
  logic [5:0]  supply_v;
  logic        hot;
  logic        on_reg;
  logic [1:0]  sel;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] rd;
  wire logic [7:0]  field;
  wire logic        thr;
  wire logic        ot;
  wire logic        soff;
  wire logic        son;
  wire logic        regp;
  wire logic [31:0] rdata;
  wire logic        wreq;
  wire logic [7:0]  outs;
  wire logic        uv_n;
  wire logic        flt_n;
  wire logic        irq;
  int          err_total;
  int          n_compared;
  // glitch rows last 3N-1 cycles, accept rows 4N+5: first tick may be partial
  odf_row_t    rows [8] = '{
    '{2'h0, 8'hA5, 4, 8'hA5}, '{2'h0, 8'h5A, 4, 8'h5A},
    '{2'h1, 8'hFF, 3*N25-1, 8'h5A}, '{2'h1, 8'hFF, 4*N25+5, 8'hFF},
    '{2'h2, 8'h00, 3*N750-1, 8'hFF}, '{2'h2, 8'h00, 4*N750+5, 8'h00},
    '{2'h3, 8'hC3, 3*N3-1, 8'h00}, '{2'h3, 8'hC3, 4*N3+5, 8'hC3}};

  odf_field_model u_field (
    .i_sensor_on(sensor_on), .i_supply_v(supply_v), .i_hot(hot),
    .i_on_regulator(on_reg), .o_field_inputs(field), .o_threshold_mode_sel(thr),
    .o_overtemp_limit(ot), .o_supply_off_threshold(soff),
    .o_supply_on_threshold(son), .o_regulator_out_pin(regp));

  odf_top #(.P_TICK_750US(15'(N750)), .P_TICK_3MS(15'(N3))) dut (
    .I_CLOCK(clk), .I_RST_N(rst_n), .I_CLK_EN(clk_en), .I_FIELD_INPUTS(field),
    .I_DEBOUNCE_SEL_LO(sel[0]), .I_DEBOUNCE_SEL_HI(sel[1]),
    .I_THRESHOLD_MODE_SEL(thr), .I_OVERTEMP_LIMIT(ot),
    .I_SUPPLY_OFF_THRESHOLD(soff), .I_SUPPLY_ON_THRESHOLD(son),
    .I_REGULATOR_OUT_PIN(regp), .I_AVS_ADDRESS(avs_address), .I_AVS_READ(avs_read),
    .I_AVS_WRITE(avs_write), .I_AVS_WRITEDATA(avs_writedata),
    .I_AVS_BYTEENABLE(4'hF), .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wreq),
    .O_LOGIC_OUTPUTS(outs), .O_SUPPLY_LOW_ALARM_N(uv_n), .O_FAULT_ALARM_N(flt_n),
    .O_IRQ(irq));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic end_of_test;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  task automatic chk_word(input string what, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : chk_word

  task automatic chk_bit(input string what, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %b seen %b", what, e, g);
    end
  endtask : chk_bit

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // one access; an edge passes after release so strobes never toggle twice
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                     output logic [31:0] q);
    logic w;
    int   k;
    k = 0;
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(negedge clk);
      w = wreq;
      q = rdata;
      @(posedge clk);
      k++;
    end while (w && k < 20);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
    if (w) begin
      err_total++;
      end_of_test();
    end
  endtask : bus

  task automatic alarms(input logic e_uv, input logic e_flt);
    cyc(6);
    @(negedge clk);
    chk_bit("supply_low_alarm_n", e_uv, uv_n);
    chk_bit("fault_alarm_n", e_flt, flt_n);
    @(posedge clk);
  endtask : alarms

  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    sensor_on = 8'h00;
    supply_v = 6'h18;
    hot = 1'b0;
    on_reg = 1'b0;
    sel = 2'h0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    err_total = 0;
    n_compared = 0;
    cyc(3);
    @(negedge clk);
    chk_word("outputs in reset", 32'h0, 32'(outs));
    chk_bit("fault_alarm_n in reset", 1'b0, flt_n);
    cyc(3);
    rst_n <= 1'b1;
    alarms(1'b1, 1'b1);
    foreach (rows[i]) begin
      sel <= rows[i].sel;
      cyc(200);
      sensor_on <= rows[i].pat;
      cyc(rows[i].len - 1);
      @(negedge clk);
      chk_word("outputs", 32'(rows[i].exp), 32'(outs));
      @(posedge clk);
      sensor_on <= rows[i].exp;
    end
    cyc(10);
    hot <= 1'b1;
    alarms(1'b1, 1'b0);
    hot <= 1'b0;
    alarms(1'b1, 1'b1);
    supply_v <= 6'h05;
    alarms(1'b0, 1'b0);
    supply_v <= 6'h0A;
    alarms(1'b0, 1'b0);
    supply_v <= 6'h18;
    alarms(1'b1, 1'b1);
    on_reg <= 1'b1;
    alarms(1'b0, 1'b0);
    on_reg <= 1'b0;
    alarms(1'b1, 1'b1);
    bus(1'b0, 4'h0, 32'h0, rd);
    chk_word("inputs reg", 32'h000000C3, rd);
    bus(1'b1, 4'h0, 32'h000000FF, rd);
    bus(1'b0, 4'h0, 32'h0, rd);
    chk_word("inputs reg after write", 32'h000000C3, rd);
    bus(1'b0, 4'h4, 32'h0, rd);
    chk_word("alarms reg", 32'h00000038, rd);
    bus(1'b0, 4'hC, 32'h0, rd);
    chk_word("mask reset", 32'h0, rd);
    bus(1'b1, 4'h8, 32'h000003FF, rd);
    bus(1'b0, 4'h8, 32'h0, rd);
    chk_word("status cleared", 32'h0, rd);
    bus(1'b1, 4'hC, 32'h00000100, rd);
    hot <= 1'b1;
    cyc(1);
    // clear lands with the overtemp event: the set must win
    bus(1'b1, 4'h8, 32'h00000100, rd);
    cyc(3);
    @(negedge clk);
    chk_bit("irq raised", 1'b1, irq);
    @(posedge clk);
    hot <= 1'b0;
    bus(1'b0, 4'h8, 32'h0, rd);
    chk_word("status overtemp", 32'h00000100, rd);
    bus(1'b1, 4'h8, 32'h00000100, rd);
    cyc(3);
    @(negedge clk);
    chk_bit("irq cleared", 1'b0, irq);
    @(posedge clk);
    supply_v <= 6'h05;
    cyc(6);
    bus(1'b0, 4'h8, 32'h0, rd);
    chk_word("status supply", 32'h00000200, rd);
    @(negedge clk);
    chk_bit("irq masked", 1'b0, irq);
    @(posedge clk);
    // enable low must freeze the whole pipe, synchronisers included
    sel <= 2'h0;
    cyc(6);
    clk_en <= 1'b0;
    sensor_on <= 8'h3C;
    cyc(8);
    @(negedge clk);
    chk_word("outputs frozen", 32'h000000C3, 32'(outs));
    @(posedge clk);
    clk_en <= 1'b1;
    cyc(3);
    @(negedge clk);
    chk_word("outputs after enable", 32'h0000003C, 32'(outs));
    @(posedge clk);
    rst_n <= 1'b0;
    cyc(2);
    @(negedge clk);
    chk_word("outputs after reset", 32'h0, 32'(outs));
    chk_bit("supply_low_alarm_n in reset", 1'b0, uv_n);
    end_of_test();
  end
endmodule : odf_top_tb
`default_nettype wire
